// *** core/timer_a_pkg.sv ***
// Package holding register offsets, control field layout and reset values of the 8-bit timer A.
package timer_a_pkg;
    localparam logic [7:0] TIMER_A_CONTROL_ADDR       = 8'hF3;
    localparam logic [7:0] TIMER_A_REFERENCE_DATA_ADDR = 8'hF4;
    localparam logic [7:0] TIMER_PENDING_FLAGS_ADDR   = 8'hF5;
    localparam logic [7:0] TIMER_A_COUNTER_ADDR       = 8'hF6;
    localparam logic [7:0] CONTROL_RESET              = 8'h00;
    localparam logic [7:0] DATA_RESET                 = 8'hFF;
    localparam logic [7:0] COUNT_MAX                  = 8'hFF;
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_MATCH_IE_BIT = 1;
    localparam int CTRL_OVF_IE_BIT  = 2;
    localparam int CTRL_CLEAR_BIT   = 3;
    localparam int CTRL_MODE_LSB    = 4;
    localparam int CTRL_CLK_LSB     = 6;
    localparam int PEND_MATCH_BIT   = 0;
    localparam int PEND_OVF_BIT     = 1;
    localparam int DIV_1024         = 1024;
    localparam int DIV_256          = 256;
    localparam int DIV_64           = 64;
    localparam int PRESCALE_WIDTH   = 10;

    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'b00,
        MODE_CAPTURE_RISE = 2'b01,
        MODE_CAPTURE_FALL = 2'b10,
        MODE_PWM      = 2'b11
    } timer_mode_t;

    typedef enum logic [1:0] {
        CLK_DIV_1024 = 2'b00,
        CLK_DIV_256  = 2'b01,
        CLK_DIV_64   = 2'b10,
        CLK_EXTERNAL = 2'b11
    } clock_select_t;
endpackage

// *** core/timer_a_sync.sv ***
// Two-flop synchroniser with an edge detector on the synchronised level.
`timescale 1ns/1ps
module timer_a_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
    assign fall  = ~sync_reg & last_reg;
endmodule

// *** core/timer_a_prescaler.sv ***
// Free-running system clock divider giving one-cycle ticks at /1024, /256 and /64.
`timescale 1ns/1ps
module timer_a_prescaler
    import timer_a_pkg::*;
#(
    parameter int WIDTH = PRESCALE_WIDTH
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick_1024,
    output logic      tick_256,
    output logic      tick_64
);
    logic [WIDTH-1:0] div_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // A tick fires while the low bits of the divider are all ones, the cycle before they roll over to zero.
    assign tick_1024 = (div_reg[$clog2(DIV_1024)-1:0] == '1);
    assign tick_256  = (div_reg[$clog2(DIV_256)-1:0] == '1);
    assign tick_64   = (div_reg[$clog2(DIV_64)-1:0] == '1);
endmodule

// *** core/timer_a.sv ***
`timescale 1ns/1ps
module timer_a
    import timer_a_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_a_external_clock_pin,
    input  wire logic       timer_a_capture_pin,
    output logic            timer_a_output_pin,
    output logic            timer_a_overflow_irq,
    output logic            timer_a_match_capture_irq,
    output logic            interrupt_request
);
    import timer_a_pkg::*;

    logic [7:0]    timer_a_control_reg;
    logic [7:0]    timer_a_reference_data_reg;
    logic [7:0]    timer_a_counter_reg;
    logic [1:0]    timer_pending_flags_reg;
    logic          out_reg;
    logic [7:0]    rdata_reg;
    logic          tick_1024;
    logic          tick_256;
    logic          tick_64;
    logic          ext_rise;
    logic          cap_rise;
    logic          cap_fall;
    logic          count_tick;
    logic          started;
    logic          match;
    logic          wrap;
    logic          capture_event;
    logic          clear_cmd;
    logic          ctrl_write;
    logic          data_write;
    logic          pend_write;
    timer_mode_t   mode;
    clock_select_t clk_sel;

    timer_a_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_prescaler (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick_1024(tick_1024),
        .tick_256 (tick_256),
        .tick_64  (tick_64)
    );

    timer_a_sync u_ext_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .pin  (timer_a_external_clock_pin),
        .level(),
        .rise (ext_rise),
        .fall ()
    );

    timer_a_sync u_cap_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .pin  (timer_a_capture_pin),
        .level(),
        .rise (cap_rise),
        .fall (cap_fall)
    );

    assign ctrl_write = reg_write && (reg_addr == TIMER_A_CONTROL_ADDR);
    assign data_write = reg_write && (reg_addr == TIMER_A_REFERENCE_DATA_ADDR);
    assign pend_write = reg_write && (reg_addr == TIMER_PENDING_FLAGS_ADDR);

    assign mode    = timer_mode_t'(timer_a_control_reg[CTRL_MODE_LSB +: 2]);
    assign clk_sel = clock_select_t'(timer_a_control_reg[CTRL_CLK_LSB +: 2]);
    assign started = timer_a_control_reg[CTRL_START_BIT];
    assign clear_cmd = ctrl_write && reg_wdata[CTRL_CLEAR_BIT];

    always_comb begin
        case (clk_sel)
            CLK_DIV_1024: count_tick = tick_1024;
            CLK_DIV_256:  count_tick = tick_256;
            CLK_DIV_64:   count_tick = tick_64;
            default:      count_tick = ext_rise;
        endcase
    end

    assign match = started && count_tick && (mode == MODE_INTERVAL)
                   && (timer_a_counter_reg == timer_a_reference_data_reg);
    assign wrap  = started && count_tick && !match && (timer_a_counter_reg == COUNT_MAX);
    assign capture_event = ((mode == MODE_CAPTURE_RISE) && cap_rise)
                           || ((mode == MODE_CAPTURE_FALL) && cap_fall);

    // The clear bit acts as a strobe and always reads back as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_control_reg <= CONTROL_RESET;
        end else if (ctrl_write) begin
            timer_a_control_reg <= reg_wdata & ~(8'h01 << CTRL_CLEAR_BIT);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_counter_reg <= 8'h00;
        end else if (clear_cmd || match) begin
            timer_a_counter_reg <= 8'h00;
        end else if (started && count_tick) begin
            timer_a_counter_reg <= timer_a_counter_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_reference_data_reg <= DATA_RESET;
        end else if (capture_event) begin
            timer_a_reference_data_reg <= timer_a_counter_reg;
        end else if (data_write) begin
            timer_a_reference_data_reg <= reg_wdata;
        end
    end

    // In PWM mode the pin is low while reference <= count and high while reference > count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else if (mode == MODE_PWM) begin
            out_reg <= (timer_a_reference_data_reg > timer_a_counter_reg);
        end else if (match) begin
            out_reg <= ~out_reg;
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_pending_flags_reg <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pend_write && !reg_wdata[i]) begin
                    timer_pending_flags_reg[i] <= 1'b0;
                end
            end
            if (match || capture_event) begin
                timer_pending_flags_reg[PEND_MATCH_BIT] <= 1'b1;
            end
            if (wrap) begin
                timer_pending_flags_reg[PEND_OVF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_read) begin
            if (reg_addr == TIMER_A_CONTROL_ADDR) begin
                rdata_reg <= timer_a_control_reg;
            end else if (reg_addr == TIMER_A_REFERENCE_DATA_ADDR) begin
                rdata_reg <= timer_a_reference_data_reg;
            end else if (reg_addr == TIMER_PENDING_FLAGS_ADDR) begin
                rdata_reg <= {6'h00, timer_pending_flags_reg};
            end else if (reg_addr == TIMER_A_COUNTER_ADDR) begin
                rdata_reg <= timer_a_counter_reg;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign timer_a_output_pin = out_reg;
    assign timer_a_match_capture_irq = timer_pending_flags_reg[PEND_MATCH_BIT]
                                       && timer_a_control_reg[CTRL_MATCH_IE_BIT];
    assign timer_a_overflow_irq = timer_pending_flags_reg[PEND_OVF_BIT]
                                  && timer_a_control_reg[CTRL_OVF_IE_BIT];
    assign interrupt_request = timer_a_overflow_irq || timer_a_match_capture_irq;

    a_interval_clear: assert property (@(posedge clk) disable iff (!rst_n)
        match && !clear_cmd |=> timer_a_counter_reg == 8'h00 && timer_pending_flags_reg[PEND_MATCH_BIT])
        else $error("Interval match did not clear counter and set pending.");
    a_interval_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        match && mode == MODE_INTERVAL |=> out_reg != $past(out_reg))
        else $error("Interval match did not toggle the output pin.");
    a_pwm_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && started && count_tick && !clear_cmd && timer_a_counter_reg == COUNT_MAX
        |=> timer_a_counter_reg == 8'h00 && timer_pending_flags_reg[PEND_OVF_BIT])
        else $error("PWM counter did not wrap with overflow.");
    a_pwm_level: assert property (@(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && $stable(mode) |=>
        out_reg == ($past(timer_a_reference_data_reg) > $past(timer_a_counter_reg)))
        else $error("PWM output level wrong.");
    a_capture_load: assert property (@(posedge clk) disable iff (!rst_n)
        capture_event |=> timer_a_reference_data_reg == $past(timer_a_counter_reg)
        && timer_pending_flags_reg[PEND_MATCH_BIT])
        else $error("Capture did not load the count.");
    a_clear_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        clear_cmd |=> timer_a_counter_reg == 8'h00 && !timer_a_control_reg[CTRL_CLEAR_BIT])
        else $error("Clear strobe did not clear counter.");
    a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !started && !clear_cmd |=> $stable(timer_a_counter_reg))
        else $error("Stopped counter moved.");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        timer_a_match_capture_irq |-> timer_a_control_reg[CTRL_MATCH_IE_BIT])
        else $error("Match interrupt while disabled.");
    a_pend_clear: assert property (@(posedge clk) disable iff (!rst_n)
        pend_write && !reg_wdata[PEND_MATCH_BIT] && !match && !capture_event
        |=> !timer_pending_flags_reg[PEND_MATCH_BIT])
        else $error("Pending flag not cleared by write of zero.");

    // Counting steps are spelled out from the register state, not from the internal strobes.
    sequence s_interval_hit;
        started && count_tick && !clear_cmd && mode == MODE_INTERVAL
        && timer_a_counter_reg == timer_a_reference_data_reg;
    endsequence

    sequence s_plain_tick;
        started && count_tick && !clear_cmd
        && !(mode == MODE_INTERVAL && timer_a_counter_reg == timer_a_reference_data_reg);
    endsequence

    sequence s_no_tick;
        !clear_cmd && (!started
            || (clk_sel == CLK_DIV_1024 && !tick_1024)
            || (clk_sel == CLK_DIV_256 && !tick_256)
            || (clk_sel == CLK_DIV_64 && !tick_64)
            || (clk_sel == CLK_EXTERNAL && !ext_rise));
    endsequence

    sequence s_top_tick;
        started && count_tick && timer_a_counter_reg == COUNT_MAX
        && !(mode == MODE_INTERVAL && timer_a_reference_data_reg == COUNT_MAX);
    endsequence

    sequence s_pwm_low;
        mode == MODE_PWM && timer_a_reference_data_reg <= timer_a_counter_reg;
    endsequence

    a_interval_hit: assert property (@(posedge clk) disable iff (!rst_n)
        s_interval_hit |=> timer_a_counter_reg == 8'h00 && out_reg != $past(out_reg)
        && timer_pending_flags_reg[PEND_MATCH_BIT])
        else $error("Interval hit did not restart, toggle and flag.");

    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        s_plain_tick |=> timer_a_counter_reg == $past(timer_a_counter_reg) + 8'h01)
        else $error("Counter did not step by one on a tick.");

    a_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
        s_no_tick |=> $stable(timer_a_counter_reg))
        else $error("Counter moved without a selected tick.");

    a_overflow_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_top_tick |=> timer_pending_flags_reg[PEND_OVF_BIT])
        else $error("Counter wrap did not flag an overflow.");

    a_pwm_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_pwm_low |=> !out_reg)
        else $error("PWM output not low while reference is at or below count.");

    a_match_hold: assert property (@(posedge clk) disable iff (!rst_n)
        timer_pending_flags_reg[PEND_MATCH_BIT] && !(pend_write && !reg_wdata[PEND_MATCH_BIT])
        |=> timer_pending_flags_reg[PEND_MATCH_BIT])
        else $error("Match pending flag cleared by itself.");

    a_ovf_hold: assert property (@(posedge clk) disable iff (!rst_n)
        timer_pending_flags_reg[PEND_OVF_BIT] && !(pend_write && !reg_wdata[PEND_OVF_BIT])
        |=> timer_pending_flags_reg[PEND_OVF_BIT])
        else $error("Overflow pending flag cleared by itself.");

    a_reset_control: assert property (@(posedge clk)
        $rose(rst_n) |-> timer_a_control_reg == CONTROL_RESET && timer_a_counter_reg == 8'h00)
        else $error("Control or counter not cleared by reset.");

    a_mc_irq_on: assert property (@(posedge clk) disable iff (!rst_n)
        timer_pending_flags_reg[PEND_MATCH_BIT] && timer_a_control_reg[CTRL_MATCH_IE_BIT]
        |-> timer_a_match_capture_irq)
        else $error("Enabled match pending gave no interrupt.");

    a_ovf_vector: assert property (@(posedge clk) disable iff (!rst_n)
        timer_pending_flags_reg[PEND_OVF_BIT] && timer_a_control_reg[CTRL_OVF_IE_BIT]
        |-> interrupt_request)
        else $error("Enabled overflow pending gave no interrupt request.");
endmodule

// *** dv/eight_bit_timer_capture_pwm_tb.sv ***
// Self-checking testbench for the 8-bit timer A with interval, capture and PWM modes.
`timescale 1ns/1ps
module eight_bit_timer_capture_pwm_tb;
    import timer_a_pkg::*;
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       ext_clk;
    logic       cap_pin;
    logic       out_pin;
    logic       ovf_irq;
    logic       mc_irq;
    logic       irq;
    int         errors;
    int         checks;
    int         cycles;
    logic [7:0] first;
    logic [7:0] rd;

    timer_a u_dut (
        .clk                        (clk),
        .rst_n                      (rst_n),
        .reg_addr                   (reg_addr),
        .reg_write                  (reg_write),
        .reg_read                   (reg_read),
        .reg_wdata                  (reg_wdata),
        .reg_rdata                  (reg_rdata),
        .timer_a_external_clock_pin (ext_clk),
        .timer_a_capture_pin        (cap_pin),
        .timer_a_output_pin         (out_pin),
        .timer_a_overflow_irq       (ovf_irq),
        .timer_a_match_capture_irq  (mc_irq),
        .interrupt_request          (irq)
    );

    always #5 clk = ~clk;

    // The whole run needs well under 10000 cycles; a hang is cut off at 20000.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[FAIL] run length expected below 20000 seen %0d", cycles);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rdreg(a, v);
        chk(name, exp, v);
    endtask

    // Each pulse is long enough to pass the two-flop synchroniser and edge detector.
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic t_reset();
        rdchk("control", TIMER_A_CONTROL_ADDR, CONTROL_RESET);
        rdchk("reference", TIMER_A_REFERENCE_DATA_ADDR, DATA_RESET);
        rdchk("pending", TIMER_PENDING_FLAGS_ADDR, 8'h00);
        rdchk("counter", TIMER_A_COUNTER_ADDR, 8'h00);
        rdchk("unmapped", 8'h10, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test reset done");
    endtask

    task automatic t_interval();
        wr(TIMER_A_REFERENCE_DATA_ADDR, 8'h03);
        wr(TIMER_A_CONTROL_ADDR, 8'hC9);
        pulse(2);
        rdchk("count", TIMER_A_COUNTER_ADDR, 8'h02);
        pulse(2);
        rdchk("count", TIMER_A_COUNTER_ADDR, 8'h00);
        rdchk("pending", TIMER_PENDING_FLAGS_ADDR, 8'h01);
        chk("match irq", 8'h00, {7'h00, mc_irq});
        chk("out", 8'h01, {7'h00, out_pin});
        wr(TIMER_A_CONTROL_ADDR, 8'hCB);
        chk("match irq", 8'h01, {7'h00, mc_irq});
        wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
        rdchk("pending", TIMER_PENDING_FLAGS_ADDR, 8'h00);
        chk("match irq", 8'h00, {7'h00, mc_irq});
        pulse(4);
        chk("out", 8'h00, {7'h00, out_pin});
        wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
        $display("test interval done");
    endtask

    task automatic t_stop_clear();
        pulse(2);
        wr(TIMER_A_CONTROL_ADDR, 8'hC0);
        pulse(2);
        rdchk("stopped count", TIMER_A_COUNTER_ADDR, 8'h02);
        wr(TIMER_A_COUNTER_ADDR, 8'h55);
        rdchk("count", TIMER_A_COUNTER_ADDR, 8'h02);
        wr(TIMER_A_CONTROL_ADDR, 8'hC8);
        rdchk("cleared count", TIMER_A_COUNTER_ADDR, 8'h00);
        rdchk("control", TIMER_A_CONTROL_ADDR, 8'hC0);
        $display("test stop and clear done");
    endtask

    task automatic t_pwm();
        wr(TIMER_A_REFERENCE_DATA_ADDR, 8'h02);
        wr(TIMER_A_CONTROL_ADDR, 8'hFD);
        repeat (3) @(posedge clk);
        chk("pwm out", 8'h01, {7'h00, out_pin});
        pulse(2);
        chk("pwm out", 8'h00, {7'h00, out_pin});
        rdchk("count", TIMER_A_COUNTER_ADDR, 8'h02);
        chk("ovf irq", 8'h00, {7'h00, ovf_irq});
        pulse(253);
        rdchk("count", TIMER_A_COUNTER_ADDR, 8'hFF);
        pulse(1);
        rdchk("wrapped", TIMER_A_COUNTER_ADDR, 8'h00);
        chk("pwm out", 8'h01, {7'h00, out_pin});
        chk("ovf irq", 8'h01, {7'h00, ovf_irq});
        chk("irq", 8'h01, {7'h00, irq});
        wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
        $display("test pwm done");
    endtask

    task automatic t_capture();
        wr(TIMER_A_CONTROL_ADDR, 8'hDB);
        pulse(5);
        cap_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rdchk("capture rise", TIMER_A_REFERENCE_DATA_ADDR, 8'h05);
        rdchk("pending", TIMER_PENDING_FLAGS_ADDR, 8'h01);
        chk("match irq", 8'h01, {7'h00, mc_irq});
        repeat (20) @(posedge clk);
        rdchk("pending held", TIMER_PENDING_FLAGS_ADDR, 8'h01);
        wr(TIMER_PENDING_FLAGS_ADDR, 8'h00);
        wr(TIMER_A_CONTROL_ADDR, 8'hE3);
        pulse(2);
        cap_pin <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk("capture fall", TIMER_A_REFERENCE_DATA_ADDR, 8'h07);
        $display("test capture done");
    endtask

    // Two reads spaced by twice the divide see exactly two ticks whatever the prescaler phase.
    task automatic t_prescale();
        int div[3] = '{DIV_1024, DIV_256, DIV_64};
        wr(TIMER_A_REFERENCE_DATA_ADDR, 8'hFF);
        for (int s = 0; s < 3; s++) begin
            wr(TIMER_A_CONTROL_ADDR, {s[1:0], 6'h09});
            rdreg(TIMER_A_COUNTER_ADDR, first);
            repeat (div[s] * 2 - 2) @(posedge clk);
            rdreg(TIMER_A_COUNTER_ADDR, rd);
            chk("prescaled ticks", 8'h02, rd - first);
        end
        $display("test prescaler done");
    endtask

    // A reset in mid-run must bring back the reset values after the block has been programmed.
    task automatic t_reset_again();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
    endtask

    initial begin
        clk       = 1'b0;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_wdata = 8'h00;
        ext_clk   = 1'b0;
        cap_pin   = 1'b0;
        errors    = 0;
        checks    = 0;
        cycles    = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_interval();
        t_stop_clear();
        t_pwm();
        t_capture();
        t_prescale();
        t_reset_again();
        conclude();
    end
endmodule
